/* logic/pwc_pkg.sv */
`default_nettype none

package pwc_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_HZ             = 10_000_000;
	localparam int PD_PULSE_MS        = 5;
	localparam int SETTLE_MS          = 20;
	localparam int BOOT_MS            = 300;
	localparam int PD_PULSE_CYCLES    = (PD_PULSE_MS * CLK_HZ + 999) / 1000;
	localparam int SETTLE_CYCLES      = (SETTLE_MS * CLK_HZ + 999) / 1000;
	localparam int BOOT_CYCLES        = (BOOT_MS * CLK_HZ) / 1000;
	localparam int TMR_W              = 22;
	localparam logic [4:0] RESET_PULSE_CYCLES = 5'h10;

	// ****************************************************************
	// Power states and host commands
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_RESET,
		ST_SLEEP,
		ST_WAKE,
		ST_BOOT_CLK,
		ST_BOOT_RAM,
		ST_BOOT_CFG,
		ST_ACTIVE,
		ST_STANDBY,
		ST_POWERDOWN
	} pwc_state_e;

	typedef enum logic [2:0] {
		CMD_ACTIVE,
		CMD_STANDBY,
		CMD_SLEEP,
		CMD_POWERDOWN,
		CMD_RESET_PULSE,
		CMD_EXTERNAL_CLOCK_SELECT,
		CMD_PIN_SLEEP_LEVEL
	} pwc_cmd_e;

	typedef struct packed {
		logic       valid;
		pwc_cmd_e   code;
		logic [7:0] arg;
	} pwc_cmd_s;

	// ****************************************************************
	// Host register access classes
	// ****************************************************************
	typedef enum logic [1:0] {
		ACC_CHIP_ID,
		ACC_ENGINE_RESET,
		ACC_OTHER
	} pwc_target_e;

	typedef struct packed {
		logic        valid;
		logic        is_read;
		pwc_target_e target;
	} pwc_access_s;

	// ****************************************************************
	// Clock and power controls
	// ****************************************************************
	typedef struct packed {
		logic osc_en;
		logic pll_en;
		logic core_clk_en;
		logic core_power_en;
		logic engine_en;
	} pwc_clk_s;

	localparam pwc_clk_s CLK_RESET = 5'h00;

	// ****************************************************************
	// Pin groups and their modes
	// ****************************************************************
	typedef enum logic [2:0] {
		PM_NORMAL,
		PM_RETAIN,
		PM_FLOAT,
		PM_PULL_LOW,
		PM_HIGH,
		PM_LOW
	} pwc_pin_mode_e;

	localparam int PIN_GROUPS = 8;
	localparam logic [2:0] PM_LAST = 3'h5;
	localparam int ARG_GROUP_LSB = 0;
	localparam int ARG_MODE_LSB  = 3;

	// Groups: display, backlight, touch reset, gpio, flash, xp/yp, xm/ym, audio.
	localparam pwc_pin_mode_e PIN_PD_DEFAULT [PIN_GROUPS] = '{
		PM_PULL_LOW, PM_PULL_LOW, PM_PULL_LOW, PM_FLOAT,
		PM_FLOAT, PM_HIGH, PM_RETAIN, PM_RETAIN
	};
	localparam pwc_pin_mode_e PIN_RESET_MODE [PIN_GROUPS] = '{
		PM_LOW, PM_LOW, PM_LOW, PM_FLOAT,
		PM_FLOAT, PM_FLOAT, PM_FLOAT, PM_FLOAT
	};

endpackage

`default_nettype wire

/* logic/pwc_power_ctrl.sv */
// What this block does
// - Resistive touch pulls the host interrupt low in standby or sleep, never in powerdown.
// - Capacitive touch: host interrupt mirrors touch controller interrupt in standby, sleep, powerdown.
// - Power-on reset produces a reset pulse to every core circuit.
// - After power-up reset the device rests in sleep until activation command.
// - Engines run only in active; activation command enters active from low power.
// - Host commands move the device into standby, sleep or powerdown.
// - Power-down pin driven low while active enters powerdown.
// - Active: oscillator, PLL and core engine clock all on.
// - Standby: oscillator and PLL run, core clock gated, registers kept.
// - Sleep: oscillator, PLL and core clock stopped, registers kept.
// - Powerdown: clocks and core power off, command interface stays alive.
// - Powerdown exit needs activation command while power-down pin is high.
// - Powerdown exit does global reset and power-up, keeping powerdown pin levels.
// - After waking from standby host access is accepted at once.
// - A 5 ms low pulse on power-down pin resets from active or standby.
// - Reset command or powerdown wake resets; after a reset command device rests in sleep, after powerdown wake it boots.
// - Activation after reset starts clocks, checks RAM, loads configuration; boot_late flags a boot longer than 300 ms.
// - Going from active to standby or sleep all pins keep their levels.
// - Powerdown pin levels are set by a dedicated host command.
// - Default pin levels at reset and in powerdown per pin group.
`timescale 1ns/1ps
`default_nettype none

module pwc_power_ctrl
	import pwc_pkg::*;
#(
	parameter logic [TMR_W-1:0] PD_PULSE_LEN = TMR_W'(PD_PULSE_CYCLES),
	parameter logic [TMR_W-1:0] SETTLE_LEN   = TMR_W'(SETTLE_CYCLES),
	parameter logic [TMR_W-1:0] BOOT_LEN     = TMR_W'(BOOT_CYCLES)
) (
	// Clock and power-on reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Host command and access
	input  wire pwc_cmd_s    host_cmd,
	input  wire pwc_access_s host_access,
	output logic             access_grant,
	// Power-down pin
	input  wire logic        powerdown_pin_n,
	// Boot helpers
	output logic             ram_check_start,
	input  wire logic        ram_check_done,
	output logic             cfg_load_start,
	input  wire logic        cfg_load_done,
	output logic             boot_busy,
	output logic             boot_late,
	// Clock, power and reset controls
	output pwc_clk_s         clk_ctrl,
	output logic             ext_clk_sel,
	output logic             core_reset,
	output logic             spi_if_enable,
	output pwc_state_e       power_state,
	// Touch and host interrupt
	input  wire logic        touch_capacitive,
	input  wire logic        resistive_touched,
	input  wire logic        touch_ctrl_irq_n,
	input  wire logic        engine_irq,
	output logic             host_int_o,
	output logic             host_int_oe,
	// Pin modes
	output pwc_pin_mode_e    pin_mode [PIN_GROUPS]
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic pwc_clk_s clk_for(input pwc_state_e s);
		pwc_clk_s c;
		c = CLK_RESET;
		c.core_power_en = 1'b1;
		case (s)
			ST_ACTIVE: begin
				c.osc_en      = 1'b1;
				c.pll_en      = 1'b1;
				c.core_clk_en = 1'b1;
				c.engine_en   = 1'b1;
			end
			ST_STANDBY, ST_WAKE, ST_BOOT_CLK: begin
				c.osc_en = 1'b1;
				c.pll_en = 1'b1;
			end
			ST_BOOT_RAM, ST_BOOT_CFG: begin
				c.osc_en      = 1'b1;
				c.pll_en      = 1'b1;
				c.core_clk_en = 1'b1;
			end
			ST_POWERDOWN: begin
				c.core_power_en = 1'b0;
			end
			default: begin
				c = c;
			end
		endcase
		return c;
	endfunction

	function automatic logic in_boot(input pwc_state_e s);
		return (s == ST_BOOT_CLK) || (s == ST_BOOT_RAM) || (s == ST_BOOT_CFG);
	endfunction

	// ****************************************************************
	// State registers
	// ****************************************************************
	pwc_state_e       state_reg, state_next;
	logic [TMR_W-1:0] tmr_reg, tmr_next;
	logic [TMR_W-1:0] boot_tmr_reg, boot_tmr_next;
	logic [TMR_W-1:0] low_cnt_reg, low_cnt_next;
	logic             pin_prev_reg;
	logic             pulse_armed_reg, pulse_armed_next;
	logic             boot_needed_reg, boot_needed_next;
	logic             wake_boot_reg, wake_boot_next;
	logic             ext_clk_reg, ext_clk_next;
	logic             boot_late_reg, boot_late_next;
	pwc_clk_s         clk_reg;
	pwc_pin_mode_e    pd_mode_reg [PIN_GROUPS];
	pwc_pin_mode_e    mode_reg [PIN_GROUPS];

	// ****************************************************************
	// Decoding
	// ****************************************************************
	wire logic          pin_low     = !powerdown_pin_n;
	wire logic          pin_rise    = powerdown_pin_n && !pin_prev_reg;
	wire logic          pin_fall    = pin_low && pin_prev_reg;
	wire logic          cmd_act     = host_cmd.valid && (host_cmd.code == CMD_ACTIVE);
	wire logic          cmd_stby    = host_cmd.valid && (host_cmd.code == CMD_STANDBY);
	wire logic          cmd_sleep   = host_cmd.valid && (host_cmd.code == CMD_SLEEP);
	wire logic          cmd_pd      = host_cmd.valid && (host_cmd.code == CMD_POWERDOWN);
	wire logic          cmd_rst     = host_cmd.valid && (host_cmd.code == CMD_RESET_PULSE);
	wire logic          cmd_extclk  = host_cmd.valid && (host_cmd.code == CMD_EXTERNAL_CLOCK_SELECT);
	wire logic          cmd_pinlvl  = host_cmd.valid && (host_cmd.code == CMD_PIN_SLEEP_LEVEL);
	wire logic [2:0]    arg_group   = host_cmd.arg[ARG_GROUP_LSB +: 3];
	wire logic [2:0]    arg_mode    = host_cmd.arg[ARG_MODE_LSB +: 3];
	wire logic          arg_mode_ok = (arg_mode <= PM_LAST);
	wire logic          long_pulse  = pin_rise && pulse_armed_reg && (low_cnt_reg >= PD_PULSE_LEN);
	wire logic          st_active   = (state_reg == ST_ACTIVE);
	wire logic          st_lowpwr   = (state_reg == ST_STANDBY) || (state_reg == ST_SLEEP);
	wire logic          st_pd       = (state_reg == ST_POWERDOWN);
	wire logic          boot_read   = host_access.is_read && (host_access.target != ACC_OTHER);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		state_next       = state_reg;
		tmr_next         = tmr_reg + TMR_W'(1);
		boot_needed_next = boot_needed_reg;
		wake_boot_next   = wake_boot_reg;
		ext_clk_next     = ext_clk_reg;
		if ((cmd_rst || long_pulse) && (state_reg != ST_RESET)) begin
			state_next     = ST_RESET;
			wake_boot_next = 1'b0;
		end else begin
			case (state_reg)
				ST_RESET: begin
					boot_needed_next = 1'b1;
					ext_clk_next     = 1'b0;
					if (tmr_reg >= TMR_W'(RESET_PULSE_CYCLES)) begin
						state_next = wake_boot_reg ? ST_BOOT_CLK : ST_SLEEP;
						wake_boot_next = 1'b0;
					end
				end
				ST_SLEEP: begin
					if (cmd_extclk) begin
						ext_clk_next = 1'b1;
					end
					if (cmd_act) begin
						state_next = boot_needed_reg ? ST_BOOT_CLK : ST_WAKE;
					end else if (cmd_pd) begin
						state_next = ST_POWERDOWN;
					end
				end
				ST_WAKE: begin
					if (tmr_reg >= SETTLE_LEN) begin
						state_next = ST_ACTIVE;
					end
				end
				ST_BOOT_CLK: begin
					if (tmr_reg >= SETTLE_LEN) begin
						state_next = ST_BOOT_RAM;
					end
				end
				ST_BOOT_RAM: begin
					if (ram_check_done) begin
						state_next = ST_BOOT_CFG;
					end
				end
				ST_BOOT_CFG: begin
					if (cfg_load_done) begin
						state_next       = ST_ACTIVE;
						boot_needed_next = 1'b0;
					end
				end
				ST_ACTIVE: begin
					if (pin_low) begin
						state_next = ST_POWERDOWN;
					end else if (cmd_stby) begin
						state_next = ST_STANDBY;
					end else if (cmd_sleep) begin
						state_next = ST_SLEEP;
					end else if (cmd_pd) begin
						state_next = ST_POWERDOWN;
					end
				end
				ST_STANDBY: begin
					if (cmd_act) begin
						state_next = ST_ACTIVE;
					end else if (cmd_pd) begin
						state_next = ST_POWERDOWN;
					end
				end
				ST_POWERDOWN: begin
					if (cmd_act && powerdown_pin_n) begin
						state_next     = ST_RESET;
						wake_boot_next = 1'b1;
					end
				end
				default: begin
					state_next = ST_RESET;
				end
			endcase
		end
		if (state_next != state_reg) begin
			tmr_next = '0;
		end
	end

	// ****************************************************************
	// Power-down pin pulse measurement
	// ****************************************************************
	always_comb begin
		low_cnt_next     = low_cnt_reg;
		pulse_armed_next = pulse_armed_reg;
		if (pin_fall) begin
			low_cnt_next     = '0;
			pulse_armed_next = st_active || (state_reg == ST_STANDBY);
		end else if (pin_low && (low_cnt_reg < PD_PULSE_LEN)) begin
			low_cnt_next = low_cnt_reg + TMR_W'(1);
		end else if (pin_rise) begin
			pulse_armed_next = 1'b0;
		end
	end

	// ****************************************************************
	// Boot watchdog
	// ****************************************************************
	always_comb begin
		boot_tmr_next  = boot_tmr_reg;
		boot_late_next = boot_late_reg;
		if (!in_boot(state_reg)) begin
			boot_tmr_next = '0;
		end else if (boot_tmr_reg < BOOT_LEN) begin
			boot_tmr_next = boot_tmr_reg + TMR_W'(1);
		end else begin
			boot_late_next = 1'b1;
		end
		if (cmd_act && (state_reg == ST_SLEEP) && boot_needed_reg) begin
			boot_late_next = 1'b0;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg       <= ST_RESET;
			tmr_reg         <= '0;
			boot_tmr_reg    <= '0;
			low_cnt_reg     <= '0;
			pin_prev_reg    <= 1'b1;
			pulse_armed_reg <= 1'b0;
			boot_needed_reg <= 1'b1;
			wake_boot_reg   <= 1'b0;
			ext_clk_reg     <= 1'b0;
			boot_late_reg   <= 1'b0;
			clk_reg         <= CLK_RESET;
		end else begin
			state_reg       <= state_next;
			tmr_reg         <= tmr_next;
			boot_tmr_reg    <= boot_tmr_next;
			low_cnt_reg     <= low_cnt_next;
			pin_prev_reg    <= powerdown_pin_n;
			pulse_armed_reg <= pulse_armed_next;
			boot_needed_reg <= boot_needed_next;
			wake_boot_reg   <= wake_boot_next;
			ext_clk_reg     <= ext_clk_next;
			boot_late_reg   <= boot_late_next;
			clk_reg         <= clk_for(state_next);
		end
	end

	// ****************************************************************
	// Pin modes per group
	// ****************************************************************
	generate
		for (genvar g = 0; g < PIN_GROUPS; g++) begin : g_pin
			wire logic    sel_g = cmd_pinlvl && arg_mode_ok && (arg_group == 3'(g));
			pwc_pin_mode_e mode_g;
			assign mode_g = (state_next == ST_RESET) ? PIN_RESET_MODE[g] :
			                (state_next == ST_POWERDOWN) ? pd_mode_reg[g] :
			                ((state_next == ST_STANDBY) || (state_next == ST_SLEEP) ||
			                 (state_next == ST_WAKE)) ? PM_RETAIN :
			                PM_NORMAL;
			always_ff @(posedge clock or posedge rst) begin
				if (rst) begin
					pd_mode_reg[g] <= PIN_PD_DEFAULT[g];
					mode_reg[g]    <= PIN_RESET_MODE[g];
				end else begin
					if (sel_g) begin
						pd_mode_reg[g] <= pwc_pin_mode_e'(arg_mode);
					end
					mode_reg[g] <= mode_g;
				end
			end
			assign pin_mode[g] = mode_reg[g];
		end
	endgenerate

	// ****************************************************************
	// Host interrupt pin, open drain
	// ****************************************************************
	wire logic cap_wake = touch_capacitive && (st_lowpwr || st_pd) && !touch_ctrl_irq_n;
	wire logic res_wake = !touch_capacitive && st_lowpwr && resistive_touched;
	wire logic eng_int  = st_active && engine_irq;

	assign host_int_o  = 1'b0;
	assign host_int_oe = cap_wake || res_wake || eng_int;

	// ****************************************************************
	// Access gating and outputs
	// ****************************************************************
	assign access_grant    = host_access.valid &&
	                         (st_active || (in_boot(state_reg) && boot_read));
	assign ram_check_start = (state_reg == ST_BOOT_RAM);
	assign cfg_load_start  = (state_reg == ST_BOOT_CFG);
	assign boot_busy       = in_boot(state_reg);
	assign boot_late       = boot_late_reg;
	assign clk_ctrl        = clk_reg;
	assign ext_clk_sel     = ext_clk_reg;
	assign core_reset      = (state_reg == ST_RESET);
	assign spi_if_enable   = 1'b1;
	assign power_state     = state_reg;

endmodule // pwc_power_ctrl

`default_nettype wire

/* bench/pwc_power_ctrl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Power control checker.
// ****
module pwc_power_ctrl_checker
	import pwc_pkg::*;
(
	// Clock and reset
	input wire logic          clock,
	input wire logic          rst,
	// Host side
	input wire pwc_cmd_s      host_cmd,
	input wire pwc_access_s   host_access,
	input wire logic          access_grant,
	input wire logic          powerdown_pin_n,
	input wire logic          boot_busy,
	// Power outputs
	input wire pwc_clk_s      clk_ctrl,
	input wire logic          core_reset,
	input wire logic          spi_if_enable,
	input wire pwc_state_e    power_state,
	// Touch and pins
	input wire logic          touch_capacitive,
	input wire logic          resistive_touched,
	input wire logic          touch_ctrl_irq_n,
	input wire logic          host_int_oe,
	input wire pwc_pin_mode_e pin_mode [PIN_GROUPS]
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_wake;
		host_cmd.valid && host_cmd.code == CMD_ACTIVE && power_state == ST_SLEEP;
	endsequence
	sequence s_to_sleep;
		host_cmd.valid && host_cmd.code == CMD_SLEEP && power_state == ST_ACTIVE && powerdown_pin_n;
	endsequence
	a_act_clocks: assert property (
		power_state == ST_ACTIVE |-> clk_ctrl == 5'h1f) else $error("Active clocks wrong.");
	a_stby_clocks: assert property (
		power_state == ST_STANDBY |-> clk_ctrl == 5'h1a) else $error("Standby clocks wrong.");
	a_sleep_clocks: assert property (
		power_state == ST_SLEEP |-> clk_ctrl == 5'h02) else $error("Sleep clocks wrong.");
	a_pd_state: assert property (
		power_state == ST_POWERDOWN |-> clk_ctrl == 5'h00 && spi_if_enable) else $error("Powerdown wrong.");
	a_touch_wake: assert property (
		power_state inside {ST_STANDBY, ST_SLEEP, ST_POWERDOWN} |-> host_int_oe == (touch_capacitive ?
		!touch_ctrl_irq_n : resistive_touched && power_state != ST_POWERDOWN)) else $error("Touch wake wrong.");
	a_engine_gate: assert property (
		clk_ctrl.engine_en |-> power_state == ST_ACTIVE) else $error("Engine on outside active.");
	a_wake_settle: assert property (
		s_wake |=> !clk_ctrl.core_clk_en [*8]) else $error("Core clock early after wake.");
	a_sleep_cmd: assert property (
		s_to_sleep |=> power_state == ST_SLEEP) else $error("Sleep command not taken.");
	a_pin_down: assert property (
		power_state == ST_ACTIVE && !powerdown_pin_n && !(host_cmd.valid && host_cmd.code == CMD_RESET_PULSE)
		|=> power_state == ST_POWERDOWN) else $error("Pin not obeyed.");
	a_reset_pulse: assert property (
		$fell(core_reset) |-> $past(core_reset, 16) && power_state inside {ST_SLEEP, ST_BOOT_CLK})
		else $error("Reset pulse wrong.");
	a_boot_deny: assert property (
		boot_busy && host_access.valid && host_access.target == ACC_OTHER |-> !access_grant)
		else $error("Boot access granted.");
	a_run_grant: assert property (
		power_state == ST_ACTIVE && host_access.valid |-> access_grant) else $error("Active access refused.");
	a_pin_keep: assert property (
		power_state inside {ST_STANDBY, ST_SLEEP} |-> pin_mode[7] == PM_RETAIN) else $error("Pins not kept.");
endmodule // pwc_power_ctrl_checker

bind pwc_power_ctrl pwc_power_ctrl_checker i_pwc_power_ctrl_checker (
	.clock(clock), .rst(rst), .host_cmd(host_cmd), .host_access(host_access),
	.access_grant(access_grant), .powerdown_pin_n(powerdown_pin_n), .boot_busy(boot_busy),
	.clk_ctrl(clk_ctrl), .core_reset(core_reset), .spi_if_enable(spi_if_enable),
	.power_state(power_state), .touch_capacitive(touch_capacitive), .resistive_touched(resistive_touched),
	.touch_ctrl_irq_n(touch_ctrl_irq_n), .host_int_oe(host_int_oe), .pin_mode(pin_mode)
);
`default_nettype wire

/* bench/pwc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Host and boot helper model.
// ****
module pwc_host_model
	import pwc_pkg::*;
(
	// Clock
	input wire logic    clock,
	// Boot helpers
	input wire logic    ram_check_start,
	input wire logic    cfg_load_start,
	output logic        ram_check_done,
	output logic        cfg_load_done,
	// Host lines
	output pwc_cmd_s    host_cmd,
	output pwc_access_s host_access,
	output logic        powerdown_pin_n
);
	int slow = 0;
	int wait_cnt = 0;
	initial begin
		host_cmd = '0;
		host_access = '0;
		powerdown_pin_n = 1'b1;
		ram_check_done = 1'b0;
		cfg_load_done = 1'b0;
	end
	// Boot helpers answer after slow cycles.
	always @(posedge clock) begin
		ram_check_done <= 1'b0;
		cfg_load_done <= 1'b0;
		wait_cnt <= ((ram_check_start || cfg_load_start) && wait_cnt != slow) ? wait_cnt + 1 : 0;
		if (wait_cnt == slow) begin
			ram_check_done <= ram_check_start;
			cfg_load_done <= cfg_load_start;
		end
	end
	task automatic send(input pwc_cmd_e c, input logic [7:0] a);
		@(posedge clock);
		host_cmd <= '{1'b1, c, a};
		@(posedge clock);
		host_cmd.valid <= 1'b0;
	endtask
	task automatic pin(input logic lvl);
		@(posedge clock);
		powerdown_pin_n <= lvl;
	endtask
	task automatic access(input logic v, input logic rd, input pwc_target_e t);
		@(posedge clock);
		host_access <= '{v, rd, t};
	endtask
endmodule // pwc_host_model
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Power control testbench.
// ****
module testbench
	import pwc_pkg::*;
;
	logic          clock, rst, touch_capacitive, resistive_touched, touch_ctrl_irq_n, engine_irq;
	logic          powerdown_pin_n, ram_check_done, cfg_load_done, ram_check_start, cfg_load_start;
	logic          access_grant, boot_busy, boot_late, ext_clk_sel, core_reset, spi_if_enable, host_int_oe, host_int_o;
	pwc_cmd_s      host_cmd;
	pwc_access_s   host_access;
	pwc_clk_s      clk_ctrl;
	pwc_state_e    power_state;
	pwc_pin_mode_e pin_mode [PIN_GROUPS];
	pwc_state_e    exp_q [$];
	logic [31:0]   rnd = 32'h39;
	int            miscompares = 0;
	int            tests_run = 0;

	pwc_power_ctrl #(.PD_PULSE_LEN(TMR_W'(20)), .SETTLE_LEN(TMR_W'(30)), .BOOT_LEN(TMR_W'(400))) i_pwc_power_ctrl (
		.clock(clock), .rst(rst), .host_cmd(host_cmd), .host_access(host_access), .access_grant(access_grant),
		.powerdown_pin_n(powerdown_pin_n), .ram_check_start(ram_check_start), .ram_check_done(ram_check_done),
		.cfg_load_start(cfg_load_start), .cfg_load_done(cfg_load_done), .boot_busy(boot_busy),
		.boot_late(boot_late), .clk_ctrl(clk_ctrl), .ext_clk_sel(ext_clk_sel), .core_reset(core_reset),
		.spi_if_enable(spi_if_enable), .power_state(power_state), .touch_capacitive(touch_capacitive),
		.resistive_touched(resistive_touched), .touch_ctrl_irq_n(touch_ctrl_irq_n), .engine_irq(engine_irq),
		.host_int_o(host_int_o), .host_int_oe(host_int_oe), .pin_mode(pin_mode));
	pwc_host_model i_pwc_host_model (
		.clock(clock), .ram_check_start(ram_check_start), .cfg_load_start(cfg_load_start),
		.ram_check_done(ram_check_done), .cfg_load_done(cfg_load_done), .host_cmd(host_cmd),
		.host_access(host_access), .powerdown_pin_n(powerdown_pin_n));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_for(input pwc_state_e s);
		int n;
		n = 0;
		while (power_state !== s) begin
			@(negedge clock);
			n++;
			if (n > 2000) begin
				check(power_state, s);
				end_of_test();
			end
		end
	endtask
	task automatic cmd(input pwc_cmd_e c, input logic [7:0] a);
		i_pwc_host_model.send(c, a);
	endtask
	task automatic go(input pwc_cmd_e c, input pwc_state_e s);
		exp_q.push_back(s);
		cmd(c, 8'h00);
		wait_for(s);
	endtask
	task automatic boot_notes(input logic from_pd);
		if (from_pd)
			exp_q.push_back(ST_RESET);
		exp_q.push_back(ST_BOOT_CLK);
		exp_q.push_back(ST_BOOT_RAM);
		exp_q.push_back(ST_BOOT_CFG);
		exp_q.push_back(ST_ACTIVE);
	endtask
	task automatic scan(input pwc_state_e s);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			rnd = xs(rnd);
			touch_capacitive <= rnd[0];
			resistive_touched <= rnd[1];
			touch_ctrl_irq_n <= rnd[2];
			engine_irq <= rnd[3];
			@(negedge clock);
			check(host_int_o, 1'b0);
			if (s == ST_ACTIVE)
				check(host_int_oe, engine_irq);
			else
				check(host_int_oe, touch_capacitive ? !touch_ctrl_irq_n : resistive_touched && s != ST_POWERDOWN);
		end
	endtask

	// Each state change is compared with the oldest note.
	initial begin
		pwc_state_e last;
		@(negedge rst);
		last = ST_RESET;
		forever begin
			@(negedge clock);
			if (power_state !== last) begin
				last = power_state;
				check(power_state, exp_q.size() > 0 ? exp_q.pop_front() : 4'hf);
			end
		end
	end

	initial begin
		rst = 1'b1;
		touch_capacitive = 1'b1;
		resistive_touched = 1'b0;
		touch_ctrl_irq_n = 1'b1;
		engine_irq = 1'b0;
		i_pwc_host_model.slow = 10;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		exp_q.push_back(ST_SLEEP);
		wait_for(ST_SLEEP);
		cmd(CMD_EXTERNAL_CLOCK_SELECT, 8'h00);
		@(negedge clock);
		check(ext_clk_sel, 1'b1);
		boot_notes(1'b0);
		cmd(CMD_ACTIVE, 8'h00);
		wait_for(ST_BOOT_RAM);
		i_pwc_host_model.access(1'b1, 1'b1, ACC_CHIP_ID);
		@(negedge clock);
		check(access_grant, 1'b1);
		i_pwc_host_model.access(1'b1, 1'b0, ACC_OTHER);
		@(negedge clock);
		check(access_grant, 1'b0);
		i_pwc_host_model.access(1'b0, 1'b0, ACC_OTHER);
		wait_for(ST_ACTIVE);
		check(boot_late, 1'b0);
		i_pwc_host_model.slow = 0;
		go(CMD_STANDBY, ST_STANDBY);
		scan(ST_STANDBY);
		go(CMD_ACTIVE, ST_ACTIVE);
		i_pwc_host_model.access(1'b1, 1'b0, ACC_OTHER);
		@(negedge clock);
		check(access_grant, 1'b1);
		i_pwc_host_model.access(1'b0, 1'b0, ACC_OTHER);
		scan(ST_ACTIVE);
		go(CMD_SLEEP, ST_SLEEP);
		scan(ST_SLEEP);
		go(CMD_ACTIVE, ST_WAKE);
		check(clk_ctrl, 5'h1a);
		exp_q.push_back(ST_ACTIVE);
		wait_for(ST_ACTIVE);
		exp_q.push_back(ST_POWERDOWN);
		i_pwc_host_model.pin(1'b0);
		wait_for(ST_POWERDOWN);
		i_pwc_host_model.pin(1'b1);
		@(negedge clock);
		for (int g = 0; g < PIN_GROUPS; g++)
			check(pin_mode[g], PIN_PD_DEFAULT[g]);
		scan(ST_POWERDOWN);
		cmd(CMD_PIN_SLEEP_LEVEL, 8'h20);
		repeat (2) @(negedge clock);
		check(pin_mode[0], PM_HIGH);
		boot_notes(1'b1);
		cmd(CMD_ACTIVE, 8'h00);
		wait_for(ST_ACTIVE);
		go(CMD_POWERDOWN, ST_POWERDOWN);
		check(pin_mode[0], PM_HIGH);
		i_pwc_host_model.pin(1'b0);
		cmd(CMD_ACTIVE, 8'h00);
		repeat (2) @(negedge clock);
		check(power_state, ST_POWERDOWN);
		i_pwc_host_model.pin(1'b1);
		i_pwc_host_model.slow = 400;
		boot_notes(1'b1);
		cmd(CMD_ACTIVE, 8'h00);
		wait_for(ST_ACTIVE);
		check(boot_late, 1'b1);
		i_pwc_host_model.slow = 0;
		go(CMD_STANDBY, ST_STANDBY);
		i_pwc_host_model.pin(1'b0);
		repeat (25) @(posedge clock);
		exp_q.push_back(ST_RESET);
		exp_q.push_back(ST_SLEEP);
		i_pwc_host_model.pin(1'b1);
		wait_for(ST_SLEEP);
		exp_q.push_back(ST_RESET);
		exp_q.push_back(ST_SLEEP);
		cmd(CMD_RESET_PULSE, 8'h00);
		wait_for(ST_RESET);
		check(pin_mode[1], PIN_RESET_MODE[1]);
		wait_for(ST_SLEEP);
		@(negedge clock);
		check(exp_q.size(), 0);
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
